// ### src/fasdo_params.svh
// Notes on behaviour
// - four axes, each independently a stepper channel or an analog setpoint channel.
// - step, direction and enable outputs leave as true and inverted pairs.
// - the number of strobes emitted equals the commanded travel.
// - strobe rate is proportional to the commanded speed.
// - direction output high commands left rotation, low commands right rotation.
// - a per-axis reversal setting inverts the direction output mapping.
// - power enable is active only while the axis enable is set and RUN mode holds.
// - the drive release contact of a used axis closes together with power enable, once axis enable, controller enable and RUN mode all hold.
// - power enable and release contact change in the same cycle.
// - analog setpoints are linearly interpolated across each servo cycle.
// - the setpoint filter can be switched off and is on after reset.
// - the setpoint filter time is configurable.
// - an unused axis turns its release contact into a general digital output.
`ifndef FASDO_PARAMS_SVH
`define FASDO_PARAMS_SVH
`define FASDO_CLK_HZ          25000000
`define FASDO_STROBE_HIGH_NS  2000
`define FASDO_STROBE_HIGH_CYC ((`FASDO_STROBE_HIGH_NS * 25 + 999) / 1000)
`define FASDO_SERVO_CYC       4000
`define FASDO_FILTER_RST      1'b1
`define FASDO_FILTER_SHIFT_RST 4'h4
`endif

// ### src/fasdo_pkg.sv
package fasdo_pkg;
    typedef enum logic {FASDO_STEPPER, FASDO_ANALOG} fasdo_mode_t;
    typedef enum {FASDO_IDLE, FASDO_HIGH, FASDO_LOW} fasdo_step_state_t;
endpackage

// ### src/fasdo_step_gen.sv
`timescale 1ns/10ps
`include "fasdo_params.svh"
module fasdo_step_gen
    import fasdo_pkg::*;
#(
    parameter int POS_W  = 32,
    parameter int RATE_W = 16,
    parameter int HIGH_C = `FASDO_STROBE_HIGH_CYC
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              moveLoad,
    input  wire logic [POS_W-1:0]  moveSteps,
    input  wire logic              moveLeft,
    input  wire logic [RATE_W-1:0] stepRate,
    input  wire logic              reverseDir,
    input  wire logic              chanActive,
    output logic                   stepStrobe,
    output logic                   rotSense,
    output logic                   moveBusy
);
    localparam int PH_W = RATE_W + 8;
    fasdo_step_state_t            state_q, state_d;
    logic [POS_W-1:0]             left_q, left_d;
    logic [PH_W-1:0]              phase_q, phase_d;
    logic [7:0]                   hcnt_q, hcnt_d;
    logic                         strobe_q, strobe_d;
    logic                         dir_q, dir_d;
    logic                         pendDir_q, pendDir_d;
    logic [PH_W:0]                phSum;

    if (HIGH_C < 1 || HIGH_C > 255) begin : g_bad_high
        $error("strobe high count out of range");
    end

    always_comb begin
        phSum     = {1'b0, phase_q} + {{(PH_W-RATE_W+1){1'b0}}, stepRate};
        state_d   = state_q;
        left_d    = left_q;
        phase_d   = phase_q;
        hcnt_d    = hcnt_q;
        strobe_d  = strobe_q;
        dir_d     = dir_q;
        pendDir_d = pendDir_q;
        if (moveLoad && chanActive) begin
            left_d    = moveSteps;
            pendDir_d = moveLeft ^ reverseDir;
        end
        unique case (state_q)
            FASDO_IDLE, FASDO_LOW: begin
                strobe_d = 1'b0;
                dir_d    = pendDir_d;
                if (!chanActive) begin
                    left_d  = '0;
                    state_d = FASDO_IDLE;
                end else if (left_d != '0 && dir_q == pendDir_d) begin
                    phase_d = phSum[PH_W-1:0];
                    if (phSum[PH_W]) begin
                        state_d  = FASDO_HIGH;
                        strobe_d = 1'b1;
                        hcnt_d   = 8'(HIGH_C - 1);
                        left_d   = left_d - 1'b1;
                    end
                end else begin
                    state_d = FASDO_IDLE;
                end
            end
            FASDO_HIGH: begin
                phase_d = phSum[PH_W-1:0];
                if (hcnt_q == 8'h00) begin
                    strobe_d = 1'b0;
                    state_d  = FASDO_LOW;
                end else begin
                    hcnt_d = hcnt_q - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q   <= FASDO_IDLE;
            left_q    <= '0;
            phase_q   <= '0;
            hcnt_q    <= 8'h00;
            strobe_q  <= 1'b0;
            dir_q     <= 1'b0;
            pendDir_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            left_q    <= left_d;
            phase_q   <= phase_d;
            hcnt_q    <= hcnt_d;
            strobe_q  <= strobe_d;
            dir_q     <= dir_d;
            pendDir_q <= pendDir_d;
        end
    end

    assign stepStrobe = strobe_q;
    assign rotSense   = dir_q;
    assign moveBusy   = (left_q != '0) || (state_q == FASDO_HIGH);
endmodule // fasdo_step_gen

// ### src/fasdo_drive_outputs.sv
`timescale 1ns/10ps
`include "fasdo_params.svh"
module fasdo_drive_outputs
    import fasdo_pkg::*;
#(
    parameter int AXES     = 4,
    parameter int POS_W    = 32,
    parameter int RATE_W   = 16,
    parameter int DAC_W    = 16,
    parameter int SERVO_C  = `FASDO_SERVO_CYC
) (
    input  wire logic                    mclk,
    input  wire logic                    sys_rst,
    input  wire logic                    runMode,
    input  wire logic [AXES-1:0]         axisAnalog,
    input  wire logic [AXES-1:0]         axisUsed,
    input  wire logic [AXES-1:0]         axisEnable,
    input  wire logic [AXES-1:0]         ctrlEnable,
    input  wire logic [AXES-1:0]         gpOutValue,
    input  wire logic [AXES-1:0]         reverseDir,
    input  wire logic [AXES-1:0]         moveLoad,
    input  wire logic [AXES*POS_W-1:0]   moveSteps,
    input  wire logic [AXES-1:0]         moveLeft,
    input  wire logic [AXES*RATE_W-1:0]  stepRate,
    input  wire logic [AXES-1:0]         setpointLoad,
    input  wire logic [AXES*DAC_W-1:0]   setpointValue,
    input  wire logic                    filterEnableWr,
    input  wire logic                    filterEnableIn,
    input  wire logic                    filterShiftWr,
    input  wire logic [3:0]              filterShiftIn,
    output logic [AXES-1:0]              stepStrobe,
    output logic [AXES-1:0]              stepStrobeN,
    output logic [AXES-1:0]              rotSense,
    output logic [AXES-1:0]              rotSenseN,
    output logic [AXES-1:0]              powerEnable,
    output logic [AXES-1:0]              powerEnableN,
    output logic [AXES-1:0]              driveReleaseContact,
    output logic [AXES-1:0]              moveBusy,
    output logic [AXES*DAC_W-1:0]        speedSetpointOut,
    output logic                         servoTick,
    output logic                         filterEnable,
    output logic [3:0]                   filterShift
);
    localparam int SC_W = $clog2(SERVO_C + 1);
    localparam int AC_W = DAC_W + SC_W + 2;

    logic [SC_W-1:0]          servo_q, servo_d;
    logic                     filtEn_q, filtEn_d;
    logic [3:0]               filtSh_q, filtSh_d;
    logic [AXES-1:0]          pEn_q, pEn_d;
    logic [AXES-1:0]          rel_q, rel_d;
    logic [AXES-1:0]          strobeRaw;
    logic [AXES-1:0]          senseRaw;
    logic [AXES-1:0]          strobe_q, sense_q;
    logic signed [DAC_W-1:0]  tgt_q  [AXES], tgt_d  [AXES];
    logic signed [DAC_W-1:0]  base_q [AXES], base_d [AXES];
    logic signed [AC_W-1:0]   acc_q  [AXES], acc_d  [AXES];
    logic signed [DAC_W-1:0]  interp_q [AXES], interp_d [AXES];
    logic signed [AC_W-1:0]   filt_q [AXES], filt_d [AXES];
    logic signed [DAC_W-1:0]  seg_q  [AXES], seg_d  [AXES];

    if (AXES < 1 || AXES > 4) begin : g_bad_axes
        $error("axis count must be 1 to 4");
    end
    if (SERVO_C < 2) begin : g_bad_servo
        $error("servo cycle too short");
    end

    for (genvar a = 0; a < AXES; a++) begin : g_step
        fasdo_step_gen #(
            .POS_W  (POS_W),
            .RATE_W (RATE_W)
        ) u_step (
            .mclk       (mclk),
            .sys_rst    (sys_rst),
            .moveLoad   (moveLoad[a]),
            .moveSteps  (moveSteps[a*POS_W +: POS_W]),
            .moveLeft   (moveLeft[a]),
            .stepRate   (stepRate[a*RATE_W +: RATE_W]),
            .reverseDir (reverseDir[a]),
            .chanActive (axisUsed[a] && !axisAnalog[a]),
            .stepStrobe (strobeRaw[a]),
            .rotSense   (senseRaw[a]),
            .moveBusy   (moveBusy[a])
        );
    end

    always_comb begin
        servo_d  = (servo_q == SC_W'(SERVO_C - 1)) ? '0 : servo_q + 1'b1;
        filtEn_d = filterEnableWr ? filterEnableIn : filtEn_q;
        filtSh_d = filterShiftWr ? filterShiftIn : filtSh_q;
        for (int a = 0; a < AXES; a++) begin
            pEn_d[a] = axisUsed[a] && axisEnable[a] && ctrlEnable[a] && runMode;
            rel_d[a] = axisUsed[a] ? pEn_d[a] : gpOutValue[a];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            servo_q  <= '0;
            filtEn_q <= `FASDO_FILTER_RST;
            filtSh_q <= `FASDO_FILTER_SHIFT_RST;
            pEn_q    <= '0;
            rel_q    <= '0;
            strobe_q <= '0;
            sense_q  <= '0;
        end else begin
            servo_q  <= servo_d;
            filtEn_q <= filtEn_d;
            filtSh_q <= filtSh_d;
            pEn_q    <= pEn_d;
            rel_q    <= rel_d;
            strobe_q <= strobeRaw;
            sense_q  <= senseRaw;
        end
    end

    // setpoint interpolation and optional first order filter
    always_comb begin
        logic signed [AC_W-1:0] delta;
        logic signed [AC_W-1:0] step;
        delta = '0;
        step  = '0;
        for (int a = 0; a < AXES; a++) begin
            tgt_d[a]    = setpointLoad[a] ? setpointValue[a*DAC_W +: DAC_W] : tgt_q[a];
            base_d[a]   = base_q[a];
            acc_d[a]    = acc_q[a];
            interp_d[a] = interp_q[a];
            filt_d[a]   = filt_q[a];
            seg_d[a]    = seg_q[a];
            if (!(axisUsed[a] && axisAnalog[a]) && axisUsed[a]) begin
                acc_d[a]    = '0;
                interp_d[a] = '0;
                base_d[a]   = '0;
                seg_d[a]    = '0;
            end else if (servo_q == '0) begin
                // new segment: start where the last one ended, aim at the latest target
                base_d[a]   = seg_q[a];
                seg_d[a]    = tgt_q[a];
                delta       = AC_W'(tgt_q[a]) - AC_W'(seg_q[a]);
                acc_d[a]    = delta;
                step        = acc_d[a] / AC_W'(SERVO_C);
                interp_d[a] = DAC_W'(AC_W'(seg_q[a]) + step);
            end else begin
                delta       = AC_W'(seg_q[a]) - AC_W'(base_q[a]);
                acc_d[a]    = acc_q[a] + delta;
                step        = acc_d[a] / AC_W'(SERVO_C);
                interp_d[a] = DAC_W'(AC_W'(base_q[a]) + step);
            end
            if (filtEn_q)
                filt_d[a] = filt_q[a] + ((AC_W'(interp_q[a]) - filt_q[a]) >>> filtSh_q);
            else
                filt_d[a] = AC_W'(interp_q[a]);
        end
    end

    always_ff @(posedge mclk) begin
        for (int a = 0; a < AXES; a++) begin
            if (sys_rst) begin
                tgt_q[a]    <= '0;
                base_q[a]   <= '0;
                acc_q[a]    <= '0;
                interp_q[a] <= '0;
                filt_q[a]   <= '0;
                seg_q[a]    <= '0;
            end else begin
                tgt_q[a]    <= tgt_d[a];
                base_q[a]   <= base_d[a];
                acc_q[a]    <= acc_d[a];
                interp_q[a] <= interp_d[a];
                filt_q[a]   <= filt_d[a];
                seg_q[a]    <= seg_d[a];
            end
        end
    end

    for (genvar a = 0; a < AXES; a++) begin : g_out
        assign speedSetpointOut[a*DAC_W +: DAC_W] = DAC_W'(filt_q[a]);
    end

    assign stepStrobe          = strobe_q;
    assign stepStrobeN         = ~strobe_q;
    assign rotSense            = sense_q;
    assign rotSenseN           = ~sense_q;
    assign powerEnable         = pEn_q;
    assign powerEnableN        = ~pEn_q;
    assign driveReleaseContact = rel_q;
    assign servoTick           = (servo_q == '0);
    assign filterEnable        = filtEn_q;
    assign filterShift         = filtSh_q;
endmodule // fasdo_drive_outputs

// ### bench/fasdo_drive_outputs_sva.sv
`timescale 1ns/10ps
`include "fasdo_params.svh"
module fasdo_drive_outputs_chk
    import fasdo_pkg::*;
#(
    parameter int AXES = 4
) (
    input wire logic            mclk,
    input wire logic            sys_rst,
    input wire logic            runMode,
    input wire logic [AXES-1:0] axisUsed,
    input wire logic [AXES-1:0] axisEnable,
    input wire logic [AXES-1:0] ctrlEnable,
    input wire logic [AXES-1:0] gpOutValue,
    input wire logic            filterEnableWr,
    input wire logic            filterEnableIn,
    input wire logic            filterShiftWr,
    input wire logic [3:0]      filterShiftIn,
    input wire logic [AXES-1:0] stepStrobe,
    input wire logic [AXES-1:0] stepStrobeN,
    input wire logic [AXES-1:0] rotSense,
    input wire logic [AXES-1:0] rotSenseN,
    input wire logic [AXES-1:0] powerEnable,
    input wire logic [AXES-1:0] powerEnableN,
    input wire logic [AXES-1:0] driveReleaseContact,
    input wire logic            filterEnable,
    input wire logic [3:0]      filterShift
);
    // high-phase length of axis 0 strobe
    logic [7:0] hiCnt_q;
    logic [7:0] hiCnt_d;
    always_comb begin
        hiCnt_d = stepStrobe[0] ? hiCnt_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge mclk) begin
        hiCnt_q <= sys_rst ? 8'h00 : hiCnt_d;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    AST_STEP_PAIR: assert property (stepStrobe == ~stepStrobeN) else $error("strobe pair");
    AST_SENSE_PAIR: assert property (rotSense == ~rotSenseN) else $error("sense pair");
    AST_EN_PAIR: assert property (powerEnable == ~powerEnableN) else $error("enable pair");
    AST_EN_CALC: assert property (!$past(sys_rst) |->
        powerEnable == $past(axisEnable & ctrlEnable & axisUsed & {AXES{runMode}}))
        else $error("power enable");
    AST_CONTACT: assert property (!$past(sys_rst) |->
        driveReleaseContact == $past((axisEnable & ctrlEnable & axisUsed & {AXES{runMode}})
        | (gpOutValue & ~axisUsed)))
        else $error("release contact");
    AST_EN_CONTACT: assert property ((powerEnable & ~driveReleaseContact) == '0)
        else $error("enable without contact");
    AST_DIR_HOLD: assert property ((stepStrobe & (rotSense ^ $past(rotSense))) == '0)
        else $error("direction moved in strobe");
    AST_WIDTH: assert property ($fell(stepStrobe[0]) |-> hiCnt_q == `FASDO_STROBE_HIGH_CYC)
        else $error("strobe width");
    AST_FILT_RST: assert property ($past(sys_rst) |-> filterEnable && filterShift == 4'h4)
        else $error("filter reset");
    AST_SHIFT_WR: assert property (filterShiftWr |=> filterShift == $past(filterShiftIn))
        else $error("filter time");
    AST_FILT_WR: assert property (filterEnableWr |=> filterEnable == $past(filterEnableIn))
        else $error("filter switch");
endmodule // fasdo_drive_outputs_chk
bind fasdo_drive_outputs fasdo_drive_outputs_chk #(.AXES(AXES)) fasdo_drive_outputs_chk_i (.*);

// ### bench/fasdo_step_unit.sv
`timescale 1ns/10ps
module fasdo_step_unit #(
    parameter bit FALL = 1'b0
) (
    input wire logic mclk,
    input wire logic stepIn,
    input wire logic senseIn,
    input wire logic enableIn,
    output int       steps,
    output int       lastGap
);
    logic prevQ = FALL;
    int   gap   = 0;
    initial steps = 0;
    initial lastGap = 0;
    // steps only while enabled, on the edge its wiring selects
    always @(posedge mclk) begin
        prevQ <= stepIn;
        gap <= gap + 1;
        if (enableIn && (FALL ? (prevQ && !stepIn) : (!prevQ && stepIn))) begin
            steps <= steps + (senseIn ? 1 : -1);
            lastGap <= gap;
            gap <= 1;
        end
    end
endmodule // fasdo_step_unit

// ### bench/fasdo_drive_outputs_tb.sv
`timescale 1ns/10ps
module fasdo_drive_outputs_tb;
    import fasdo_pkg::*;
    logic mclk = 0, sys_rst = 1, runMode = 0, fEnWr = 0, fEnIn = 1, fShWr = 0;
    logic [3:0] axisAnalog = 4'h0, axisUsed = 4'hF, axisEnable = 4'h0, ctrlEnable = 4'h0;
    logic [3:0] gpOut = 4'h0, revDir = 4'h0, mvLoad = 4'h0, mvLeft = 4'h0, spLoad = 4'h0;
    logic [3:0] fShIn = 4'h4, strobe, strobeN, sense, senseN, pwrEn, pwrEnN, contact, busy, fSh;
    logic [127:0] mvSteps = '0;
    logic [63:0] rate = '0, spVal = '0, spOut;
    logic servoTick, fEn;
    logic [15:0] prevSp, maxStep;
    int failCount = 0, nChecks = 0, stepsT, stepsF, gapT, base, nTick = 0;
    always #20 mclk = ~mclk;
    fasdo_drive_outputs #(.SERVO_C(16)) fasdo_drive_outputs_i (.mclk(mclk), .sys_rst(sys_rst),
        .runMode(runMode), .axisAnalog(axisAnalog), .axisUsed(axisUsed), .axisEnable(axisEnable),
        .ctrlEnable(ctrlEnable), .gpOutValue(gpOut), .reverseDir(revDir), .moveLoad(mvLoad),
        .moveSteps(mvSteps), .moveLeft(mvLeft), .stepRate(rate), .setpointLoad(spLoad),
        .setpointValue(spVal), .filterEnableWr(fEnWr), .filterEnableIn(fEnIn),
        .filterShiftWr(fShWr), .filterShiftIn(fShIn), .stepStrobe(strobe), .stepStrobeN(strobeN),
        .rotSense(sense), .rotSenseN(senseN), .powerEnable(pwrEn), .powerEnableN(pwrEnN),
        .driveReleaseContact(contact), .moveBusy(busy), .speedSetpointOut(spOut),
        .servoTick(servoTick), .filterEnable(fEn), .filterShift(fSh));
    fasdo_step_unit #(.FALL(1'b0)) unit_rise_i (.mclk(mclk), .stepIn(strobe[0]),
        .senseIn(sense[0]), .enableIn(pwrEn[0]), .steps(stepsT), .lastGap(gapT));
    fasdo_step_unit #(.FALL(1'b1)) unit_fall_i (.mclk(mclk), .stepIn(strobeN[0]),
        .senseIn(sense[0]), .enableIn(pwrEn[0]), .steps(stepsF), .lastGap());
    task automatic completeRun;
        if (failCount == 0 && nChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        nChecks++;
        if (g !== e) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic move(input int ax, input logic left, input logic [15:0] r);
        @(posedge mclk);
        mvSteps[ax*32+:32] <= 32'h00000002;
        mvLeft[ax] <= left;
        rate[ax*16+:16] <= r;
        mvLoad[ax] <= 1'b1;
        @(posedge mclk);
        mvLoad[ax] <= 1'b0;
    endtask
    initial begin
        repeat (80000) @(posedge mclk);
        failCount++;
        completeRun();
    end
    initial begin
        tick(20);
        sys_rst <= 1'b0;
        tick(1);
        cmp("strobeN", 4'hF, strobeN);
        cmp("filterEnable", 1, fEn);
        cmp("filterShift", 4'h4, fSh);
        runMode <= 1'b1;
        axisEnable <= 4'hF;
        ctrlEnable <= 4'hF;
        tick(3);
        cmp("powerEnable", 4'hF, pwrEn);
        cmp("contact", 4'hF, contact);
        runMode <= 1'b0;
        tick(3);
        cmp("powerEnable", 4'h0, pwrEn);
        cmp("contact", 4'h0, contact);
        runMode <= 1'b1;
        axisUsed <= 4'h7;
        gpOut <= 4'h8;
        tick(3);
        cmp("contact", 4'hF, contact);
        cmp("powerEnable", 4'h7, pwrEn);
        for (int k = 0; k < 4; k++) begin
            base = stepsT;
            revDir[0] <= k[1];
            move(0, k[0], 16'h1000);
            tick(2);
            cmp("rotSense", k[0] ^ k[1], sense[0]);
            for (int w = 0; w < 9000 && busy[0] === 1'b1; w++) tick(1);
            tick(2);
            cmp("steps", base + ((k[0] ^ k[1]) ? 2 : -2), stepsT);
            cmp("gap", 4096, gapT);
            cmp("fall steps", stepsT, stepsF);
        end
        axisAnalog <= 4'h4;
        move(2, 1'b0, 16'hFFFF);
        tick(300);
        cmp("refused busy", 0, busy[2]);
        cmp("refused strobe", 0, strobe[2]);
        fEnIn <= 1'b0;
        fEnWr <= 1'b1;
        fShIn <= 4'h7;
        fShWr <= 1'b1;
        spVal[47:32] <= 16'h1000;
        spLoad[2] <= 1'b1;
        @(posedge mclk);
        fEnWr <= 1'b0;
        fShWr <= 1'b0;
        spLoad[2] <= 1'b0;
        tick(1);
        cmp("filter off", 0, fEn);
        cmp("filter time", 4'h7, fSh);
        maxStep = 16'h0000;
        prevSp = spOut[47:32];
        repeat (48) begin
            tick(1);
            if (servoTick === 1'b1) nTick++;
            if (spOut[47:32] - prevSp > maxStep) maxStep = spOut[47:32] - prevSp;
            prevSp = spOut[47:32];
        end
        cmp("setpoint", 16'h1000, spOut[47:32]);
        cmp("setpoint slope", 1, maxStep <= 16'h0101);
        cmp("servoTick", 3, nTick);
        completeRun();
    end
endmodule // fasdo_drive_outputs_tb
